// ==== hw/term_regs.sv ====
/*
 * host control register bank of a dual-redundant terminal: second
 * configuration register, stack pointer / start-reset command location,
 * controller message control word, plus the time tag counter and the
 * interrupt output shaping these registers steer.
 * assumes host strobes are one-cycle pulses synchronous to sys_clk and
 * that the protocol engines supply the event inputs as one-cycle pulses.
 */
// Operation
// - overwrite bit lets bad circular data be overwritten
// - wrap bit zero gives 256 word buffers
// - resolution codes 0-5 give 64 to 2 us
// - code 110 steps tag on host command
// - code 111 steps tag on external clock
// - sync-clear bit zeroes tag on sync
// - sync-data bit loads or sends tag word
// - status clears on read or by command
// - level mode holds irq, else 500ns pulse
// - auto-clear drops service bit after vector command
// - enhanced bit picks per-subaddress or global buffering
// - separation bit splits broadcast data storage
// - stack location reads stack or instruction pointer
// - self-test completion or online bit restarts terminal
// - command bits start self-tests, clear results
// - halt at message end or frame end
// - command bits clear tag and interrupt status
// - command bits start controller/monitor, software reset
// - set mask bits ignore received status bits
// - control word bit sends tag as sync word
// - bus select, loopback and retry enable
// - low three bits choose message format
// - double-buffer bit enables receive double buffering unless the per-subaddress bit is set
// - second configuration register read/write at 0x2
`timescale 1ns/10ps
`default_nettype none
module term_regs
    import term_regs_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 5
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] host_addr,
    input wire logic host_wr_stb,
    input wire logic host_rd_stb,
    input wire logic [DATA_W-1:0] host_wdata,
    output logic [DATA_W-1:0] host_rdata,
    output logic host_rdata_valid,
    input wire logic [DATA_W-1:0] cmd_stack_ptr,
    input wire logic [DATA_W-1:0] instr_list_ptr,
    input wire logic enhanced_ctrl_mode,
    input wire logic terminal_mode,
    input wire logic tag_ext_clk,
    input wire logic sync_cmd_seen,
    input wire logic sync_data_seen,
    input wire logic [DATA_W-1:0] sync_data_word,
    output logic [DATA_W-1:0] tag_count,
    output logic send_tag_as_sync,
    input wire logic status1_read,
    input wire logic status2_read,
    output logic status1_clear,
    output logic status2_clear,
    input wire logic irq_event,
    input wire logic irq_status_pending,
    output logic irq_n,
    input wire logic tx_vector_done,
    output logic service_bit_clear,
    input wire logic selftest_done,
    output logic terminal_online,
    output logic [DATA_W-1:0] cmd_pulse,
    output logic overwrite_bad_circular_data,
    output logic short_buffer_wrap,
    output rx_buffer_t rx_buffer_mode,
    output logic broadcast_data_separate,
    input wire logic [DATA_W-1:0] rx_status_word,
    output logic status_flagged,
    output logic primary_bus_select,
    output logic offline_loopback_test,
    output logic retry_allow,
    output logic message_end_irq_request,
    output logic protocol_revision_select,
    output msg_format_t message_format_code,
    output logic format_unused
);
    ////////////////////////////////////////////////////////////////////
    // registers and decode
    logic [DATA_W-1:0] config2_q; // second configuration
    logic [DATA_W-1:0] ctrl_word_q; // controller message control word
    logic [DATA_W-1:0] cmd_q; // self-clearing command pulses
    logic [DATA_W-1:0] rdata_q; // registered read data
    logic rvalid_q; // read data valid
    logic [DATA_W-1:0] tag_q; // time tag counter
    logic [PRESCALE_W-1:0] presc_q; // internal timebase divider
    logic ext_clk_q; // previous external tag clock level
    logic [4:0] irq_cnt_q; // pulse-mode low time left
    logic wr_cfg, wr_cmd, wr_cw; // write decodes
    logic [2:0] res_code; // tag resolution select
    logic [PRESCALE_W-1:0] step_cyc; // cycles per tag step
    logic tag_tick; // one tag advance this cycle
    logic tag_clr; // zero the counter this cycle

    assign wr_cfg = host_wr_stb && host_addr == LOC_CONFIG2;
    assign wr_cmd = host_wr_stb && host_addr == LOC_STACK_CMD;
    assign wr_cw = host_wr_stb && host_addr == LOC_CTRL_WORD;

    // configuration register, host read/write
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            config2_q <= CONFIG2_RESET;
        end else if (wr_cfg) begin
            config2_q <= host_wdata;
        end
    end

    // control word register, host read/write
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_word_q <= CTRL_WORD_RESET;
        end else if (wr_cw) begin
            ctrl_word_q <= host_wdata;
        end
    end

    // command bits live for one cycle only; reserved bits are dropped
    // so a careless host cannot fire undefined actions
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_q <= ZERO_WORD;
        end else if (wr_cmd) begin
            cmd_q <= host_wdata & ~CMD_RESERVED_MASK;
        end else begin
            cmd_q <= ZERO_WORD;
        end
    end
    assign cmd_pulse = cmd_q;

    // read path; the shared location reads the pointer, never commands
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= ZERO_WORD;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= host_rd_stb;
            if (host_rd_stb) begin
                case (host_addr)
                    LOC_CONFIG2: rdata_q <= config2_q;
                    LOC_STACK_CMD: begin
                        // pointer choice follows controller flavour
                        rdata_q <= enhanced_ctrl_mode ? instr_list_ptr
                                                      : cmd_stack_ptr;
                    end
                    LOC_CTRL_WORD: rdata_q <= ctrl_word_q;
                    default: rdata_q <= ZERO_WORD; // unmapped reads zero
                endcase
            end
        end
    end
    assign host_rdata = rdata_q;
    assign host_rdata_valid = rvalid_q;

    ////////////////////////////////////////////////////////////////////
    // time tag counter
    assign res_code = config2_q[CF_RES_HI:CF_RES_LO];

    // cycles per step: 64 us halved per code step
    always_comb begin
        step_cyc = PRESCALE_W'((RES_COARSE_US * CLK_MHZ) >> res_code);
    end

    // internal divider only runs for the timed codes
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            presc_q <= '0;
        end else if (res_code >= RES_MANUAL || presc_q >= step_cyc - 1'b1) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + 1'b1;
        end
    end

    // external clock edge detect; input already synchronous
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_clk_q <= 1'b0;
        end else begin
            ext_clk_q <= tag_ext_clk;
        end
    end

    always_comb begin
        case (res_code)
            RES_MANUAL: tag_tick = cmd_q[CMD_TAG_STEP];
            RES_EXTERNAL: tag_tick = tag_ext_clk && !ext_clk_q;
            default: tag_tick = presc_q == step_cyc - 1'b1;
        endcase
    end

    assign tag_clr = cmd_q[CMD_TAG_CLR] ||
                     (config2_q[CF_SYNC_CLR] && sync_cmd_seen);

    // clear beats load beats step
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tag_q <= ZERO_WORD;
        end else if (tag_clr) begin
            tag_q <= ZERO_WORD;
        end else if (config2_q[CF_SYNC_DAT] && terminal_mode &&
                     sync_data_seen) begin
            tag_q <= sync_data_word;
        end else if (tag_tick) begin
            tag_q <= tag_q + 1'b1;
        end
    end
    assign tag_count = tag_q;
    // controller sends tag only when both bits are set
    assign send_tag_as_sync = ctrl_word_q[CW_SEND_TAG] &&
                              config2_q[CF_SYNC_DAT];

    ////////////////////////////////////////////////////////////////////
    // interrupt status clearing and output shaping
    assign status1_clear = cmd_q[CMD_IRQ_CLR] ||
                           (config2_q[CF_CLR_READ] && status1_read);
    assign status2_clear = cmd_q[CMD_IRQ_CLR] ||
                           (config2_q[CF_CLR_READ] && status2_read);

    // pulse mode: fixed low time per new event, retrigger restarts it
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_cnt_q <= '0;
        end else begin
            if (irq_event) begin
                irq_cnt_q <= 5'(IRQ_PULSE_CYC);
            end else if (irq_cnt_q != '0) begin
                irq_cnt_q <= irq_cnt_q - 1'b1;
            end
        end
    end
    // level mode tracks pending status until both registers clear
    assign irq_n = config2_q[CF_LEVEL] ? !irq_status_pending
                                       : (irq_cnt_q == '0);

    ////////////////////////////////////////////////////////////////////
    // terminal service and online control
    assign service_bit_clear = config2_q[CF_SRV_CLR] && tx_vector_done;
    assign terminal_online = selftest_done || cmd_q[CMD_ONLINE];

    ////////////////////////////////////////////////////////////////////
    // buffering options
    assign overwrite_bad_circular_data = config2_q[CF_OVERWRITE];
    assign short_buffer_wrap = !config2_q[CF_WRAP];
    always_comb begin
        if (config2_q[CF_PER_SA]) begin
            rx_buffer_mode = BUF_PER_SA;
        end else if (config2_q[CF_RECEIVE_DOUBLE_BUFFER]) begin
            rx_buffer_mode = BUF_DOUBLE;
        end else begin
            rx_buffer_mode = BUF_SINGLE;
        end
    end
    assign broadcast_data_separate = config2_q[CF_BCST_SEP];

    ////////////////////////////////////////////////////////////////////
    // controller message attributes
    // a mask bit turns its status condition into don't-care
    assign status_flagged =
        (rx_status_word[SW_ME] && !ctrl_word_q[CW_MASK_ME]) ||
        (rx_status_word[SW_SRQ] && !ctrl_word_q[CW_MASK_SRQ]) ||
        (rx_status_word[SW_BSY] && !ctrl_word_q[CW_MASK_BSY]) ||
        (rx_status_word[SW_SSF] && !ctrl_word_q[CW_MASK_SSF]) ||
        (rx_status_word[SW_TF] && !ctrl_word_q[CW_MASK_TF]) ||
        (|rx_status_word[SW_RSV_HI:SW_RSV_LO] &&
         !ctrl_word_q[CW_MASK_RSV]) ||
        (rx_status_word[SW_BCR] && !ctrl_word_q[CW_MASK_BCR]);
    assign primary_bus_select = ctrl_word_q[CW_BUS_A];
    assign offline_loopback_test = ctrl_word_q[CW_LOOPBACK];
    assign retry_allow = ctrl_word_q[CW_RETRY];
    assign message_end_irq_request = ctrl_word_q[CW_EOM_IRQ];
    assign protocol_revision_select = ctrl_word_q[CW_REV_A];
    assign message_format_code = msg_format_t'(ctrl_word_q[CW_FMT_HI:0]);
    assign format_unused = message_format_code == FMT_UNUSED_A ||
                           message_format_code == FMT_UNUSED_B;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    AST_CFG_WRITE: assert property (
        wr_cfg |=> config2_q == $past(host_wdata))
        else $error("config write not stored");
    AST_CMD_SELF_CLEAR: assert property (
        wr_cmd ##1 !wr_cmd |=> cmd_q == ZERO_WORD)
        else $error("command pulse did not clear");
    AST_STACK_READ: assert property (
        host_rd_stb && host_addr == LOC_STACK_CMD && !enhanced_ctrl_mode
        |=> host_rdata == $past(cmd_stack_ptr) && host_rdata_valid)
        else $error("stack pointer read wrong");
    AST_TAG_CLEAR: assert property (
        cmd_q[CMD_TAG_CLR] |=> tag_q == ZERO_WORD)
        else $error("tag not cleared by command");
    AST_TAG_SYNC_CLEAR: assert property (
        config2_q[CF_SYNC_CLR] && sync_cmd_seen |=> tag_q == ZERO_WORD)
        else $error("tag not cleared on sync");
    AST_TAG_MANUAL: assert property (
        res_code == RES_MANUAL && !tag_clr && !sync_data_seen &&
        !cmd_q[CMD_TAG_STEP] |=> tag_q == $past(tag_q))
        else $error("manual tag moved without command");
    AST_TAG_STEP_64: assert property (
        res_code == 3'h0 && tag_tick && !tag_clr && !sync_data_seen
        |=> tag_q == $past(tag_q) + 1'b1)
        else $error("tag step missed");
    AST_IRQ_PULSE: assert property (
        !config2_q[CF_LEVEL] && irq_event && !wr_cfg
        |=> !irq_n [*8])
        else $error("irq pulse too short");
    AST_IRQ_LEVEL: assert property (
        config2_q[CF_LEVEL] && irq_status_pending |-> !irq_n)
        else $error("level irq not held");
    AST_CLEAR_CMD: assert property (
        cmd_q[CMD_IRQ_CLR] |-> status1_clear && status2_clear)
        else $error("status clear command lost");
    AST_NO_READ_CLEAR: assert property (
        !config2_q[CF_CLR_READ] && !cmd_q[CMD_IRQ_CLR]
        |-> !status1_clear && !status2_clear)
        else $error("status cleared by read when off");
    AST_SEND_TAG: assert property (
        wr_cw && host_wdata[CW_SEND_TAG] && config2_q[CF_SYNC_DAT] && !wr_cfg
        |=> send_tag_as_sync)
        else $error("tag not sent as sync word");
    AST_MASK: assert property (
        ctrl_word_q[CW_MASK_BSY] && rx_status_word == 16'h0008
        |-> !status_flagged)
        else $error("masked busy flagged");

    COV_CMD_WRITE: cover property (wr_cmd ##1 cmd_q != ZERO_WORD);
    COV_EXT_TAG: cover property (res_code == RES_EXTERNAL && tag_tick);
    COV_IRQ_PULSE: cover property (irq_event ##1 !irq_n);
    COV_ENH_READ: cover property (
        host_rd_stb && host_addr == LOC_STACK_CMD && enhanced_ctrl_mode);
endmodule
`default_nettype wire

// ==== hw/term_regs_pkg.sv ====
/*
 * constants for the terminal host control register bank: register
 * locations, field positions, reset values, tag timebase figures.
 * assumes a 16-bit host data path and word-indexed register locations.
 */
package term_regs_pkg;
    // register locations (word index on the host port)
    localparam logic [4:0] LOC_CONFIG2 = 5'h02;
    localparam logic [4:0] LOC_STACK_CMD = 5'h03;
    localparam logic [4:0] LOC_CTRL_WORD = 5'h04;
    localparam logic [15:0] CONFIG2_RESET = 16'h0000;
    localparam logic [15:0] CTRL_WORD_RESET = 16'h0000;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    // reserved command bits 15:12 and 8, never fired
    localparam logic [15:0] CMD_RESERVED_MASK = 16'hf100;

    // second configuration register fields
    localparam int CF_RECEIVE_DOUBLE_BUFFER = 12;
    localparam int CF_OVERWRITE = 11;
    localparam int CF_WRAP = 10;
    localparam int CF_RES_HI = 9;
    localparam int CF_RES_LO = 7;
    localparam int CF_SYNC_CLR = 6;
    localparam int CF_SYNC_DAT = 5;
    localparam int CF_CLR_READ = 4;
    localparam int CF_LEVEL = 3;
    localparam int CF_SRV_CLR = 2;
    localparam int CF_PER_SA = 1;
    localparam int CF_BCST_SEP = 0;

    // start/reset command bits
    localparam int CMD_ONLINE = 11;
    localparam int CMD_ST_CLR = 10;
    localparam int CMD_RAM_ST = 9;
    localparam int CMD_LOGIC_ST = 7;
    localparam int CMD_HALT_MSG = 6;
    localparam int CMD_HALT_FRM = 5;
    localparam int CMD_TAG_STEP = 4;
    localparam int CMD_TAG_CLR = 3;
    localparam int CMD_IRQ_CLR = 2;
    localparam int CMD_START = 1;
    localparam int CMD_SOFT_RST = 0;

    // controller message control word fields
    localparam int CW_SEND_TAG = 15;
    localparam int CW_MASK_ME = 14;
    localparam int CW_MASK_SRQ = 13;
    localparam int CW_MASK_BSY = 12;
    localparam int CW_MASK_SSF = 11;
    localparam int CW_MASK_TF = 10;
    localparam int CW_MASK_RSV = 9;
    localparam int CW_RETRY = 8;
    localparam int CW_BUS_A = 7;
    localparam int CW_LOOPBACK = 6;
    localparam int CW_MASK_BCR = 5;
    localparam int CW_EOM_IRQ = 4;
    localparam int CW_REV_A = 3;
    localparam int CW_FMT_HI = 2;

    // received status word bit positions
    localparam int SW_ME = 10;
    localparam int SW_SRQ = 8;
    localparam int SW_RSV_HI = 7;
    localparam int SW_RSV_LO = 5;
    localparam int SW_BCR = 4;
    localparam int SW_BSY = 3;
    localparam int SW_SSF = 2;
    localparam int SW_TF = 0;

    // tag resolution codes and timebase
    localparam logic [2:0] RES_MANUAL = 3'h6;
    localparam logic [2:0] RES_EXTERNAL = 3'h7;
    localparam int CLK_MHZ = 25;
    localparam int RES_COARSE_US = 64;
    localparam int PRESCALE_W = 11;
    localparam int IRQ_PULSE_NS = 500;
    localparam int CLK_PERIOD_NS = 40;
    localparam int IRQ_PULSE_CYC =
        (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // message formats
    typedef enum logic [2:0] {
        FMT_CTRL_TO_TERM = 3'b000,
        FMT_TERM_TO_TERM = 3'b001,
        FMT_BCAST = 3'b010,
        FMT_BCAST_T2T = 3'b011,
        FMT_MODE = 3'b100,
        FMT_UNUSED_A = 3'b101,
        FMT_BCAST_MODE = 3'b110,
        FMT_UNUSED_B = 3'b111
    } msg_format_t;

    // receive buffering choice
    typedef enum logic [1:0] {
        BUF_SINGLE = 2'b00,
        BUF_DOUBLE = 2'b01,
        BUF_PER_SA = 2'b10
    } rx_buffer_t;
endpackage

// ==== bench/host_proc_model.sv ====
/*
 * host processor model: drives the word-wide register port of the
 * terminal control bank with one-cycle read and write strobes.
 * assumes the bank answers a read exactly one cycle after the strobe.
 */
`timescale 1ns/10ps
`default_nettype none
module host_proc_model
    import term_regs_pkg::*;
(
    input wire logic sys_clk,
    output logic [4:0] host_addr,
    output logic host_wr_stb,
    output logic host_rd_stb,
    output logic [15:0] host_wdata,
    input wire logic [15:0] host_rdata,
    input wire logic host_rdata_valid
);
    ////////////////////////////////////////
    // idle bus: strobes low, lines parked at junk
    initial begin
        host_addr = 5'h1f;
        host_wr_stb = 1'b0;
        host_rd_stb = 1'b0;
        host_wdata = 16'ha5a5;
    end

    // one write; released lines are inverted so stale data never helps
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        host_addr <= a;
        host_wdata <= d;
        host_wr_stb <= 1'b1;
        @(posedge sys_clk);
        host_wr_stb <= 1'b0;
        host_addr <= ~a;
        host_wdata <= ~d;
        #1;
    endtask

    // command write: reserved bits always go out as zero
    task automatic cmd_wr(input logic [15:0] d);
        wr(LOC_STACK_CMD, d & 16'h0eff);
    endtask

    // one read; hands back {valid, data} of the answer cycle
    task automatic rd(input logic [4:0] a, output logic [16:0] q);
        @(posedge sys_clk);
        host_addr <= a;
        host_rd_stb <= 1'b1;
        @(posedge sys_clk);
        host_rd_stb <= 1'b0;
        host_addr <= ~a;
        #1;
        q = {host_rdata_valid, host_rdata};
    endtask
endmodule
`default_nettype wire

// ==== bench/terminal_host_control_registers_tb_top.sv ====
/*
 * self-checking bench of the terminal host control register bank.
 * assumes the host model drives the register port; event inputs are
 * one-cycle pulses made here.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("unexpected %s exp %0h got %0h", nm, e, g); \
    end \
end
module terminal_host_control_registers_tb_top;
    import term_regs_pkg::*;
    typedef struct packed {
        logic [4:0] loc;
        logic [15:0] dat;
        logic [13:0] dec;
    } row_t;
    // register writes and the decoded fields they should give
    localparam row_t ROWS [11] = '{'{LOC_CONFIG2, 16'h0800, 14'h3000},
        '{LOC_CONFIG2, 16'h1401, 14'h0600},
        '{LOC_CONFIG2, 16'h1002, 14'h1800},
        '{LOC_CTRL_WORD, 16'h0185, 14'h198b},
        '{LOC_CTRL_WORD, 16'h005e, 14'h187c},
        '{LOC_CTRL_WORD, 16'h0007, 14'h180f},
        '{LOC_CTRL_WORD, 16'h0003, 14'h1806},
        '{LOC_CTRL_WORD, 16'h0004, 14'h1808},
        '{LOC_CTRL_WORD, 16'h0000, 14'h1800},
        '{LOC_CTRL_WORD, 16'h0001, 14'h1802},
        '{LOC_CTRL_WORD, 16'h0002, 14'h1804}};
    localparam int MBIT [7] = '{CW_MASK_ME, CW_MASK_SRQ, CW_MASK_BSY,
        CW_MASK_SSF, CW_MASK_TF, CW_MASK_RSV, CW_MASK_BCR};
    localparam int SBIT [7] = '{SW_ME, SW_SRQ, SW_BSY, SW_SSF, SW_TF,
        SW_RSV_LO, SW_BCR};
    // config, event bit, expected {clr1, clr2, service, online}
    localparam logic [15:0] PC [6] = '{16'h0010, 16'h0010, 16'h0000,
        16'h0004, 16'h0000, 16'h0000};
    localparam int PB [6] = '{2, 3, 2, 5, 5, 6};
    localparam logic [3:0] PE [6] = '{4'h8, 4'h4, 4'h0, 4'h2, 4'h0, 4'h1};
    localparam logic [15:0] MAN = 16'(RES_MANUAL) << CF_RES_LO;
    localparam logic [15:0] EXT = 16'(RES_EXTERNAL) << CF_RES_LO;
    logic sys_clk, sys_rst, host_wr_stb, host_rd_stb, host_rdata_valid;
    logic [4:0] host_addr;
    logic [15:0] host_wdata, host_rdata, tag_count, cmd_pulse;
    logic [15:0] cmd_stack_ptr, instr_list_ptr, sync_data_word;
    logic [15:0] rx_status_word;
    logic enhanced_ctrl_mode, terminal_mode, tag_ext_clk;
    logic irq_status_pending, send_tag_as_sync, irq_n, status_flagged;
    logic status1_clear, status2_clear, service_bit_clear, terminal_online;
    logic overwrite_bad_circular_data, short_buffer_wrap, format_unused;
    logic broadcast_data_separate, primary_bus_select, retry_allow;
    logic offline_loopback_test, message_end_irq_request;
    logic protocol_revision_select;
    rx_buffer_t rx_buffer_mode;
    msg_format_t message_format_code;
    logic [6:0] ev; // engine event pulses
    logic [13:0] dec; // decoded register fields
    logic [16:0] q;
    int err_count, cmp_count, n;
    assign dec = {overwrite_bad_circular_data, short_buffer_wrap,
        rx_buffer_mode, broadcast_data_separate, retry_allow,
        primary_bus_select, offline_loopback_test, message_end_irq_request,
        protocol_revision_select, message_format_code, format_unused};

    term_regs u_term_regs (.sync_cmd_seen(ev[0]), .sync_data_seen(ev[1]),
        .status1_read(ev[2]), .status2_read(ev[3]), .irq_event(ev[4]),
        .tx_vector_done(ev[5]), .selftest_done(ev[6]), .*);
    host_proc_model u_host_proc_model (.*);

    ////////////////////////////////////////
    task automatic w(input logic [4:0] a, input logic [15:0] d);
        u_host_proc_model.wr(a, d);
    endtask
    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic ev_on(input int b);
        @(posedge sys_clk);
        ev <= 7'h01 << b;
        #1;
    endtask
    // free-running timebase: edges between two tag steps
    task automatic step_len(input int code);
        logic [15:0] t;
        w(LOC_CONFIG2, 16'(code) << CF_RES_LO);
        for (int k = 0; k < 2; k++) begin
            t = tag_count;
            n = 0;
            while (tag_count === t && n < 2000) begin
                tick();
                n++;
            end
        end
        `CHK("tag step", (CLK_MHZ * RES_COARSE_US) >> code, n);
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d of %0d checks", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // watchdog: the whole sequence needs well under 12000 cycles
    initial begin
        repeat (30000) @(posedge sys_clk);
        err_count++;
        tally_and_finish();
    end
    initial begin
        {sys_rst, ev, enhanced_ctrl_mode, terminal_mode} = '1;
        {enhanced_ctrl_mode, terminal_mode, tag_ext_clk, ev} = '0;
        {irq_status_pending, sync_data_word, rx_status_word} = '0;
        cmd_stack_ptr = 16'h1357;
        instr_list_ptr = 16'h2468;
        {err_count, cmp_count} = '0;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        `CHK("reset fields", 14'h1000, dec);
        `CHK("reset irq tag", 17'h10000, {irq_n, tag_count});
        u_host_proc_model.rd(LOC_CONFIG2, q);
        `CHK("cfg2 reset", {1'b1, CONFIG2_RESET}, q);
        u_host_proc_model.rd(LOC_STACK_CMD, q);
        `CHK("stack ptr", {1'b1, cmd_stack_ptr}, q);
        enhanced_ctrl_mode <= 1'b1;
        u_host_proc_model.rd(LOC_STACK_CMD, q);
        `CHK("list ptr", {1'b1, instr_list_ptr}, q);
        u_host_proc_model.rd(5'h1f, q);
        `CHK("unmapped", {1'b1, ZERO_WORD}, q);
        // table of writes, decoded fields and read-back
        foreach (ROWS[i]) begin
            w(ROWS[i].loc, ROWS[i].dat);
            `CHK("decode", ROWS[i].dec, dec);
            u_host_proc_model.rd(ROWS[i].loc, q);
            `CHK("readback", {1'b1, ROWS[i].dat}, q);
        end
        // each status condition seen, then hidden by its mask
        for (int i = 0; i < 7; i++) begin
            rx_status_word <= 16'h0001 << SBIT[i];
            w(LOC_CTRL_WORD, ZERO_WORD);
            `CHK("unmasked", 1'b1, status_flagged);
            w(LOC_CTRL_WORD, 16'h0001 << MBIT[i]);
            `CHK("masked", 1'b0, status_flagged);
        end
        // every command bit, then reserved bits alone are dropped
        u_host_proc_model.cmd_wr(16'hffff);
        `CHK("cmd bits", 16'h0eff, cmd_pulse);
        q = 17'({status1_clear, status2_clear, terminal_online});
        `CHK("cmd side", 3'b111, q);
        w(LOC_STACK_CMD, 16'hf100);
        `CHK("reserved", ZERO_WORD, cmd_pulse);
        for (int c = 0; c < 6; c++) step_len(c);
        // manual stepping, clear by command and by sync
        w(LOC_CONFIG2, MAN | 16'h0040);
        u_host_proc_model.cmd_wr(16'h0001 << CMD_TAG_CLR);
        tick();
        `CHK("tag clear", ZERO_WORD, tag_count);
        u_host_proc_model.cmd_wr(16'h0001 << CMD_TAG_STEP);
        u_host_proc_model.cmd_wr(16'h0001 << CMD_TAG_STEP);
        tick();
        `CHK("tag manual", 16'h0002, tag_count);
        ev_on(0);
        ev_on(7);
        tick();
        `CHK("tag sync", ZERO_WORD, tag_count);
        w(LOC_CONFIG2, MAN | 16'h0020);
        terminal_mode <= 1'b1;
        sync_data_word <= 16'hbeef;
        ev_on(1);
        ev_on(7);
        tick();
        `CHK("tag load", 16'hbeef, tag_count);
        w(LOC_CTRL_WORD, 16'h8000);
        `CHK("send tag", 1'b1, send_tag_as_sync);
        w(LOC_CONFIG2, EXT);
        `CHK("send off", 1'b0, send_tag_as_sync);
        u_host_proc_model.cmd_wr(16'h0001 << CMD_TAG_CLR);
        repeat (3) begin
            @(posedge sys_clk) tag_ext_clk <= 1'b1;
            repeat (2) @(posedge sys_clk) tag_ext_clk <= 1'b0;
            repeat (2) @(posedge sys_clk);
        end
        repeat (4) tick();
        `CHK("tag external", 16'h0003, tag_count);
        // side pulses steered by configuration bits
        for (int i = 0; i < 6; i++) begin
            w(LOC_CONFIG2, PC[i]);
            ev_on(PB[i]);
            q = 17'({status1_clear, status2_clear, service_bit_clear,
                terminal_online});
            `CHK("side pulse", PE[i], q);
            ev_on(7);
        end
        // pulse style interrupt, then level style
        ev_on(4);
        ev_on(7);
        n = 0;
        repeat (20) begin
            if (irq_n === 1'b0) n++;
            tick();
        end
        `CHK("irq pulse", IRQ_PULSE_CYC, n);
        w(LOC_CONFIG2, 16'h0008);
        irq_status_pending <= 1'b1;
        tick();
        `CHK("irq level", 1'b0, irq_n);
        irq_status_pending <= 1'b0;
        tick();
        `CHK("irq release", 1'b1, irq_n);
        tally_and_finish();
    end
endmodule
`default_nettype wire
